/* File: include/oria_regs.svh */
// constants for the or-immediate-to-accumulator datapath
`ifndef ORIA_REGS_SVH
`define ORIA_REGS_SVH
`define ORIA_OPC_HI 4'h0
`define ORIA_OPC_LO 4'h9
`define ORIA_OPC_HI_MSB 15
`define ORIA_OPC_HI_LSB 12
`define ORIA_OPC_LO_MSB 11
`define ORIA_OPC_LO_LSB 8
`define ORIA_IMM_MSB 7
`define ORIA_NEG_BIT 7
`define ORIA_ACC_RESET 8'h00
`define ORIA_ZERO_BYTE 8'h00
`define ORIA_INSTR_RESET 16'h0000
`define ORIA_STATUS_RESET 5'h00
`endif

/* File: include/oria_pkg.sv */
// types for the or-immediate-to-accumulator datapath
package oria_pkg;
  typedef enum logic [1:0] {
    ORIA_Q1 = 2'b00,
    ORIA_Q2 = 2'b01,
    ORIA_Q3 = 2'b10,
    ORIA_Q4 = 2'b11
  } oria_phase_e;
  typedef struct packed {
    logic neg;
    logic zero;
  } oria_flags_s;
endpackage : oria_pkg

/* File: verilog/oria_core.sv */
// or-immediate-to-accumulator execution datapath
//
// Contract
// - result is accumulator bitwise OR the 8-bit immediate from the instruction word.
// - result goes back to the accumulator only; no file register is written.
// - only negative and zero flags change; other status flags keep their values.
// - decode when opcode bits 15:12 are 0000 and bits 11:8 are 1001.
// - one program word, finished within a single instruction cycle.
// - phase one decodes, two reads literal, three ORs, four writes accumulator.
`timescale 1ns/1ps
`include "oria_regs.svh"
module oria_core #(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [DATA_W-1:0] acc_load_i,
  input wire logic acc_load_i_en_i,
  input wire logic [4:0] other_status_i,
  output logic [DATA_W-1:0] acc_o,
  output oria_pkg::oria_flags_s flags_o,
  output logic [4:0] other_status_o,
  output oria_pkg::oria_phase_e phase_o,
  output logic done_o
);

  // ---------------------------------------------------------------
  // decode helper
  // ---------------------------------------------------------------
  function automatic logic is_or_imm(input logic [15:0] w);
    is_or_imm = (w[`ORIA_OPC_HI_MSB:`ORIA_OPC_HI_LSB] == `ORIA_OPC_HI) &&
                (w[`ORIA_OPC_LO_MSB:`ORIA_OPC_LO_LSB] == `ORIA_OPC_LO);
  endfunction : is_or_imm

  function automatic oria_pkg::oria_phase_e oria_phase_next(input oria_pkg::oria_phase_e p);
    oria_phase_next = oria_pkg::oria_phase_e'(p + 2'b01);
  endfunction : oria_phase_next

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  oria_pkg::oria_phase_e phase_q, phase_d;
  logic [15:0] instr_q, instr_d;
  logic hit_q, hit_d;
  logic [DATA_W-1:0] imm_q, imm_d;
  logic [DATA_W-1:0] res_q, res_d;
  logic [DATA_W-1:0] acc_q, acc_d;
  oria_pkg::oria_flags_s flags_q, flags_d;
  logic [4:0] other_q, other_d;
  logic done_q, done_d;
  logic [DATA_W-1:0] or_bits;
  logic write_now;

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  // the phases run free: a cycle that decodes nothing still takes all four,
  // so instruction timing never depends on the opcode
  always_comb
  begin
    phase_d = phase_q;
    unique case (phase_q)
      oria_pkg::ORIA_Q1: phase_d = oria_pkg::ORIA_Q2;
      oria_pkg::ORIA_Q2: phase_d = oria_pkg::ORIA_Q3;
      oria_pkg::ORIA_Q3: phase_d = oria_pkg::ORIA_Q4;
      oria_pkg::ORIA_Q4: phase_d = oria_pkg::ORIA_Q1;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      phase_q <= oria_pkg::ORIA_Q1;
    end
    else if (clk_en_i)
    begin
      phase_q <= phase_d;
    end
  end

  // ---------------------------------------------------------------
  // decode and literal fetch
  // ---------------------------------------------------------------
  always_comb
  begin
    instr_d = instr_q;
    hit_d = hit_q;
    imm_d = imm_q;
    if (phase_q == oria_pkg::ORIA_Q1)
    begin
      // a miss or an empty slot leaves hit low and the cycle idles
      instr_d = instr_i;
      hit_d = instr_valid_i && is_or_imm(instr_i);
    end
    if (phase_q == oria_pkg::ORIA_Q2)
    begin
      imm_d = DATA_W'(instr_q[`ORIA_IMM_MSB:0]);
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      instr_q <= `ORIA_INSTR_RESET;
      hit_q <= 1'b0;
      imm_q <= `ORIA_ACC_RESET;
    end
    else if (clk_en_i)
    begin
      instr_q <= instr_d;
      hit_q <= hit_d;
      imm_q <= imm_d;
    end
  end

  // ---------------------------------------------------------------
  // or datapath
  // ---------------------------------------------------------------
  // one gate per bit: no carry chain, so every result bit settles alike
  for (genvar b = 0; b < DATA_W; b++)
  begin : g_or_bit
    assign or_bits[b] = acc_q[b] | imm_q[b];
  end

  assign write_now = (phase_q == oria_pkg::ORIA_Q4) && hit_q;

  // ---------------------------------------------------------------
  // accumulator and status
  // ---------------------------------------------------------------
  always_comb
  begin
    res_d = res_q;
    acc_d = acc_q;
    flags_d = flags_q;
    other_d = other_status_i;
    done_d = 1'b0;
    if (phase_q == oria_pkg::ORIA_Q3)
    begin
      res_d = or_bits;
    end
    if (write_now)
    begin
      // the write wins over an external accumulator load in the same cycle
      acc_d = res_q;
      flags_d.neg = res_q[`ORIA_NEG_BIT];
      flags_d.zero = (res_q == `ORIA_ZERO_BYTE);
      done_d = 1'b1;
    end
    else if (acc_load_i_en_i)
    begin
      acc_d = acc_load_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      res_q <= `ORIA_ACC_RESET;
      acc_q <= `ORIA_ACC_RESET;
      flags_q <= '0;
      other_q <= `ORIA_STATUS_RESET;
      done_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      res_q <= res_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      other_q <= other_d;
      done_q <= done_d;
    end
  end

  assign acc_o = acc_q;
  assign flags_o = flags_q;
  assign other_status_o = other_q;
  assign phase_o = phase_q;
  assign done_o = done_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_or_result: assert property (clk_en_i && phase_q == oria_pkg::ORIA_Q3 ##1 clk_en_i |-> ##1
    (!hit_q || acc_q == ($past(acc_q, 2) | $past(imm_q, 2))))
    else $error("accumulator not equal to or result");
  a_acc_hold_miss: assert property (clk_en_i && !acc_load_i_en_i &&
    !(phase_q == oria_pkg::ORIA_Q4 && hit_q) |=> $stable(acc_q))
    else $error("accumulator changed without hit");
  a_flags_only_q4: assert property (clk_en_i &&
    !(phase_q == oria_pkg::ORIA_Q4 && hit_q) |=> $stable(flags_q))
    else $error("flags changed outside write phase");
  a_other_pass: assert property (clk_en_i |=> other_q == $past(other_status_i))
    else $error("other status flags altered");
  a_decode_hit: assert property (clk_en_i && phase_q == oria_pkg::ORIA_Q1 |=> hit_q == ($past(instr_valid_i) &&
    $past(instr_i[`ORIA_OPC_HI_MSB:`ORIA_OPC_LO_LSB]) == {`ORIA_OPC_HI, `ORIA_OPC_LO}))
    else $error("opcode decode mismatch");
  a_one_cycle: assert property (done_q |-> phase_q == oria_pkg::ORIA_Q1)
    else $error("completion outside cycle boundary");
  a_done_timing: assert property (clk_en_i && phase_q == oria_pkg::ORIA_Q1 && instr_valid_i &&
    instr_i[`ORIA_OPC_HI_MSB:`ORIA_OPC_LO_LSB] == {`ORIA_OPC_HI, `ORIA_OPC_LO} ##1 clk_en_i [*3] |=> done_q)
    else $error("write not done after four phases");
  a_phase_walk: assert property (clk_en_i |=> phase_q == oria_phase_next($past(phase_q)))
    else $error("phase sequence broken");
  a_freeze_hold: assert property (!clk_en_i |=> $stable(phase_q) && $stable(acc_q) && $stable(flags_q))
    else $error("state moved while clock enable low");
  a_zero_flag: assert property (done_q |-> flags_q.zero == (acc_q == `ORIA_ZERO_BYTE))
    else $error("zero flag wrong");
  a_neg_flag: assert property (done_q |-> flags_q.neg == acc_q[`ORIA_NEG_BIT])
    else $error("negative flag wrong");

  c_hit_done: cover property (done_q);
  c_zero_result: cover property (done_q && flags_q.zero);
  c_neg_result: cover property (done_q && flags_q.neg);
  c_miss_cycle: cover property (phase_q == oria_pkg::ORIA_Q4 && !hit_q);
  c_load_collide: cover property (clk_en_i && write_now && acc_load_i_en_i);

endmodule : oria_core

/* File: tb/test_or_literal_into_accumulator.sv */
// self-checking bench for the or-immediate-to-accumulator datapath
`timescale 1ns/1ps
module test_or_literal_into_accumulator;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [15:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0;
  logic [7:0] acc_load_i = 8'h00;
  logic acc_load_i_en_i = 1'b0;
  logic [4:0] other_status_i = 5'h15;
  logic [7:0] acc_o;
  oria_pkg::oria_flags_s flags_o;
  logic [4:0] other_status_o;
  oria_pkg::oria_phase_e phase_o;
  logic done_o;
  logic [7:0] acc_m = 8'h00;
  logic [1:0] flg_m = 2'h0;
  int n_fail = 0;
  int checks_done = 0;

  oria_core oria_core_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .acc_load_i(acc_load_i),
    .acc_load_i_en_i(acc_load_i_en_i), .other_status_i(other_status_i), .acc_o(acc_o),
    .flags_o(flags_o), .other_status_o(other_status_o), .phase_o(phase_o), .done_o(done_o));

  initial
  begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic load_acc(input logic [7:0] v);
    @(negedge ref_clk_i);
    acc_load_i = v;
    acc_load_i_en_i = 1'b1;
    @(negedge ref_clk_i);
    acc_load_i_en_i = 1'b0;
    acc_m = v;
    chk(acc_o, v);
  endtask : load_acc

  // enters at a falling edge; an op right after another starts at once
  task automatic run_op(input logic [15:0] ins, input logic vld);
    int i;
    logic hit;
    i = 0;
    hit = vld && ins[15:8] == 8'h09;
    while (phase_o !== oria_pkg::ORIA_Q1 && i < 8)
    begin
      @(negedge ref_clk_i);
      i++;
    end
    instr_i = ins;
    instr_valid_i = vld;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(acc_o, acc_m);
    chk(8'(done_o), 8'h00);
    if (hit)
    begin
      acc_m = acc_m | ins[7:0];
      flg_m = {acc_m[7], acc_m == 8'h00};
    end
    @(negedge ref_clk_i);
    chk(acc_o, acc_m);
    chk(8'(flags_o), 8'(flg_m));
    chk(8'(done_o), 8'(hit));
    chk(8'(other_status_o), 8'(other_status_i));
    chk(8'(phase_o), 8'h00);
  endtask : run_op

  task automatic t_example;
    load_acc(8'h9A);
    run_op(16'h0935, 1'b1);
    run_op(16'h0940, 1'b1);
  endtask : t_example

  task automatic t_refused;
    run_op(16'h1935, 1'b1);
    run_op(16'h0835, 1'b1);
    run_op(16'h0901, 1'b0);
  endtask : t_refused

  task automatic t_flags;
    load_acc(8'h00);
    other_status_i = 5'h0A;
    run_op(16'h0900, 1'b1);
    run_op(16'h0971, 1'b1);
  endtask : t_flags

  // clock enable low for three cycles mid-op; the op resumes where it stopped
  task automatic t_freeze;
    while (phase_o !== oria_pkg::ORIA_Q1) @(negedge ref_clk_i);
    instr_i = 16'h0902;
    instr_valid_i = 1'b1;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    clk_en_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk(8'(phase_o), 8'h01);
    chk(acc_o, acc_m);
    clk_en_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    acc_m = acc_m | 8'h02;
    chk(acc_o, acc_m);
    chk(8'(done_o), 8'h01);
    chk(8'(flags_o), {6'h00, acc_m[7], acc_m == 8'h00});
  endtask : t_freeze

  // an accumulator load that meets the op's write loses to it
  task automatic t_collide;
    while (phase_o !== oria_pkg::ORIA_Q1) @(negedge ref_clk_i);
    instr_i = 16'h0980;
    instr_valid_i = 1'b1;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    acc_load_i = 8'h01;
    acc_load_i_en_i = 1'b1;
    @(negedge ref_clk_i);
    acc_load_i_en_i = 1'b0;
    acc_m = acc_m | 8'h80;
    chk(acc_o, acc_m);
    chk(8'(flags_o), {6'h00, acc_m[7], acc_m == 8'h00});
  endtask : t_collide

  task automatic finish_test;
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    reset_i = 1'b0;
    chk(acc_o, 8'h00);
    chk(8'(flags_o), 8'h00);
    chk(8'(phase_o), 8'h00);
    t_example();
    t_refused();
    t_flags();
    t_freeze();
    t_collide();
    finish_test();
  end

  // all ops together need well under 150 cycles
  initial
  begin
    repeat (400) @(posedge ref_clk_i);
    n_fail++;
    finish_test();
  end
endmodule : test_or_literal_into_accumulator
